// >>> logic/capture_buffer_control.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] read one byte per read clock
// [RULE2] reader never raises read enable during write
// [RULE3] store one byte per sample clock
// [RULE4] write enable synchronised before use
// [RULE5] synchronised write enable driven out
// [RULE6] reset pin clears all control logic; code clears pointers, count and flags, not writeEnableSynced or readValid
// [RULE7] out-of-range flag sticky during capture
// [RULE8] out-of-range cleared by readout or reset
// [RULE9] full flag when all locations unread
// [RULE10] full without auto-stop wraps and overwrites
// [RULE11] full flag drops on read or reset
// [RULE12] empty flag when nothing unread
// [RULE13] empty flag drops when writing starts
// [RULE14] auto-stop freezes contents when full
module capture_buffer_control (
  input  wire logic       mclk,              // sample clock, 40 MHz
  input  wire logic       rst_n,             // asynchronous reset, active low
  input  wire logic       readClock,         // free running read clock pin
  input  wire logic       readEnable,        // read enable pin
  input  wire logic       writeEnable,       // write enable pin, asynchronous
  input  wire logic       resetPin,          // capture reset pin, active high
  input  wire logic       autoStopWrite,     // stop writing when full
  input  wire logic [7:0] sampleData,        // converter sample, mclk domain
  input  wire logic       overRange,         // converter over range, mclk domain
  output logic            writeEnableSynced, // write enable after synchroniser
  output logic            bufferFullFlag,    // buffer full
  output logic            bufferEmptyFlag,   // buffer empty
  output logic            outOfRangeFlag,    // sticky out of range
  output logic [7:0]      readData,          // byte read out
  output logic            readValid          // readData updated this cycle
);
  function automatic logic isFull(input logic [12:0] fill);
    return fill == capture_pkg::DEPTH;
  endfunction : isFull

  logic [4:0]  syncMeta;
  logic [4:0]  syncStable;
  logic        rclkPrev;
  logic [11:0] wrPtr;
  logic [11:0] rdPtr;
  logic [12:0] count;
  logic [12:0] next_count;
  logic        readPending;
  logic        clear;
  logic        wenLive;
  logic        stopOnFull;
  logic        readStrobe;
  logic        fullNow;
  logic        emptyNow;
  logic        doWrite;
  logic        doRead;
  logic        overwrite;

  capture_mem_if memPort ();

  capture_mem store (
    .mclk (mclk),
    .port (memPort)
  );

  // every pin passes two flops; only the second stage is used below
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      syncMeta   <= capture_pkg::SYNC_RST_VAL;
      syncStable <= capture_pkg::SYNC_RST_VAL;
    end else begin
      syncMeta   <= {resetPin, autoStopWrite, writeEnable, readEnable, readClock};
      syncStable <= syncMeta;
    end
  end

  assign clear      = syncStable[capture_pkg::SYNC_RST];
  assign wenLive    = syncStable[capture_pkg::SYNC_WEN];                  // RULE4
  assign stopOnFull = syncStable[capture_pkg::SYNC_ASW];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rclkPrev <= 1'b0;
    end else begin
      rclkPrev <= syncStable[capture_pkg::SYNC_RCLK];
    end
  end

  // one read per rising read clock edge while read enable is high
  assign readStrobe = syncStable[capture_pkg::SYNC_RCLK] & ~rclkPrev
                    & syncStable[capture_pkg::SYNC_REN];                  // RULE1
  // auto-stop leaves the pointers alone, so the oldest bytes survive
  assign fullNow    = isFull(count);
  assign emptyNow   = (count == capture_pkg::COUNT_RST);
  assign doWrite    = wenLive & ~clear & ~(fullNow & stopOnFull);         // RULE3 RULE14
  assign doRead     = readStrobe & ~clear & ~emptyNow;                    // RULE1
  // overflow drops the oldest byte, so the read side moves along too
  assign overwrite  = doWrite & fullNow & ~doRead;                        // RULE10

  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = capture_pkg::COUNT_RST;                                // RULE6
    end else if (doWrite && !doRead && !fullNow) begin
      next_count = 13'(count + 13'h0001);
    end else if (doRead && !doWrite) begin
      next_count = 13'(count - 13'h0001);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= capture_pkg::COUNT_RST;
      wrPtr <= capture_pkg::PTR_RST;
      rdPtr <= capture_pkg::PTR_RST;
    end else begin
      count <= next_count;
      if (clear) begin
        wrPtr <= capture_pkg::PTR_RST;                                    // RULE6
        rdPtr <= capture_pkg::PTR_RST;
      end else begin
        if (doWrite) begin
          wrPtr <= 12'(wrPtr + 12'h001);                                  // RULE3 RULE10
        end
        if (doRead || overwrite) begin
          rdPtr <= 12'(rdPtr + 12'h001);                                  // RULE10
        end
      end
    end
  end

  assign memPort.we    = doWrite;
  assign memPort.waddr = wrPtr;
  assign memPort.wdata = sampleData;
  assign memPort.re    = doRead;
  assign memPort.raddr = rdPtr;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      writeEnableSynced <= 1'b0;
    end else begin
      writeEnableSynced <= wenLive;                                       // RULE5
    end
  end

  // flags follow next_count so they move in the same cycle as the fill
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bufferFullFlag  <= capture_pkg::FULL_RST;
      bufferEmptyFlag <= capture_pkg::EMPTY_RST;
    end else begin
      bufferFullFlag  <= isFull(next_count);                              // RULE9 RULE11
      bufferEmptyFlag <= (next_count == capture_pkg::COUNT_RST);          // RULE12 RULE13
    end
  end

  // a new over-range sample beats the clear of the last readout
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      outOfRangeFlag <= capture_pkg::RANGE_RST;
    end else if (clear) begin
      outOfRangeFlag <= capture_pkg::RANGE_RST;                           // RULE8
    end else if (overRange && doWrite) begin
      outOfRangeFlag <= 1'b1;                                             // RULE7
    end else if (doRead && count == 13'h0001) begin
      outOfRangeFlag <= 1'b0;                                             // RULE8
    end
  end

  // one cycle for the memory register, one for the output register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readPending <= 1'b0;
      readValid   <= 1'b0;
      readData    <= capture_pkg::DATA_RST;
    end else begin
      readPending <= doRead;
      readValid   <= readPending;
      if (readPending) begin
        readData <= memPort.rdata;                                        // RULE1
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_read_one_byte: assert property (doRead |=> ##1 readValid) // RULE1
    else $error("read strobe did not yield a byte");
  chk_write_advance: assert property (doWrite |=> wrPtr == 12'($past(wrPtr) + 12'h001)) // RULE3
    else $error("write did not advance pointer");
  chk_wen_synced: assert property ($rose(writeEnableSynced) |-> $past(writeEnable, 3)) // RULE4 RULE5
    else $error("synced write enable rose without input");
  chk_reset_clears: assert property (clear |=> count == 13'h0000 && bufferEmptyFlag // RULE6 RULE8 RULE11
                                     && !bufferFullFlag && !outOfRangeFlag)
    else $error("reset pin did not clear control");
  chk_range_sticky: assert property (outOfRangeFlag && !clear && !(doRead && count == 13'h0001) // RULE7
                                     |=> outOfRangeFlag)
    else $error("out of range flag dropped early");
  chk_range_readout: assert property (doRead && count == 13'h0001 && !(overRange && doWrite) // RULE8
                                      |=> !outOfRangeFlag)
    else $error("out of range flag kept after readout");
  // pointers meet both when full and when empty, so the flags tell the two apart
  chk_full_match: assert property (bufferFullFlag == (wrPtr == rdPtr && !bufferEmptyFlag)) // RULE9
    else $error("full flag disagrees with fill");
  chk_wrap_overwrite: assert property (overwrite && !stopOnFull // RULE10
                                       |=> rdPtr == 12'($past(rdPtr) + 12'h001) && bufferFullFlag)
    else $error("overflow did not overwrite oldest");
  chk_full_drop: assert property (bufferFullFlag && doRead && !doWrite |=> !bufferFullFlag) // RULE11
    else $error("full flag kept after read");
  chk_empty_match: assert property (bufferEmptyFlag == (wrPtr == rdPtr && !bufferFullFlag)) // RULE12
    else $error("empty flag disagrees with fill");
  chk_empty_drop: assert property (bufferEmptyFlag && doWrite |=> !bufferEmptyFlag) // RULE13
    else $error("empty flag kept after write");
  chk_auto_stop: assert property (fullNow && stopOnFull && wenLive && !clear && !doRead
                                  |=> $stable(wrPtr) && bufferFullFlag) // RULE14
    else $error("auto stop did not hold contents");

  cov_wrap: cover property (overwrite);
  cov_fill: cover property ($rose(bufferFullFlag));
  cov_read: cover property (doRead ##2 readValid);
  cov_drain: cover property ($rose(bufferEmptyFlag));
  cov_auto_stop: cover property (fullNow && stopOnFull && wenLive && !clear);
endmodule : capture_buffer_control
`default_nettype wire

// >>> logic/capture_pkg.sv
`default_nettype none
package capture_pkg;
  localparam int         DATA_WIDTH   = 8;
  localparam int         ADDR_WIDTH   = 12;
  localparam int         COUNT_WIDTH  = 13;
  localparam logic [12:0] DEPTH       = 13'h1000;
  localparam int         SYNC_WIDTH   = 5;
  // bit positions of the pin inputs inside the synchroniser vector
  localparam int         SYNC_RCLK    = 0;
  localparam int         SYNC_REN     = 1;
  localparam int         SYNC_WEN     = 2;
  localparam int         SYNC_ASW     = 3;
  localparam int         SYNC_RST     = 4;
  localparam logic [4:0] SYNC_RST_VAL = 5'h00;
  localparam logic       FULL_RST     = 1'b0;
  localparam logic       EMPTY_RST    = 1'b1;
  localparam logic       RANGE_RST    = 1'b0;
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [11:0] PTR_RST     = 12'h000;
  localparam logic [12:0] COUNT_RST   = 13'h0000;
endpackage : capture_pkg
`default_nettype wire

// >>> logic/capture_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface capture_mem_if;
  logic       we;
  logic [11:0] waddr;
  logic [7:0] wdata;
  logic       re;
  logic [11:0] raddr;
  logic [7:0] rdata;
  modport ctrl  (output we, waddr, wdata, re, raddr, input rdata);
  modport store (input we, waddr, wdata, re, raddr, output rdata);
endinterface : capture_mem_if
`default_nettype wire

// >>> logic/capture_mem.sv
`timescale 1ns/1ps
`default_nettype none
module capture_mem (
  input wire logic     mclk,   // sample clock
  capture_mem_if.store port    // write and read port
);
  logic [capture_pkg::DATA_WIDTH-1:0] cells [0:(1 << capture_pkg::ADDR_WIDTH)-1];

  // read sees the old byte when both ports hit one address
  always_ff @(posedge mclk) begin
    if (port.we) begin
      cells[port.waddr] <= port.wdata;
    end
    if (port.re) begin
      port.rdata <= cells[port.raddr];
    end
  end
endmodule : capture_mem
`default_nettype wire

// >>> bench/capture_reader.sv
`timescale 1ns/1ps
`default_nettype none
module capture_reader (
  input  wire logic wantRead,    // bench asks for reads
  input  wire logic writeEnable, // write enable pin
  output logic      readClock,   // free running read clock
  output logic      readEnable   // read enable pin
);
  // odd start offset keeps the read clock out of phase with mclk
  initial begin
    readClock = 1'b0;
    readEnable = 1'b0;
    #37;
    forever #100 readClock = ~readClock;
  end
  // a request that arrives during a write waits for the write to end
  always @(wantRead or writeEnable) begin
    if (!wantRead) readEnable = 1'b0;
    else if (!writeEnable) readEnable = 1'b1;
  end
endmodule : capture_reader
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errorCnt++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb_top;
  logic       mclk = 1'b0, rst_n = 1'b0, writeEnable = 1'b0, resetPin = 1'b0, autoStopWrite = 1'b0;
  logic       overRange = 1'b0, wantRead = 1'b0, expOr = 1'b0, readClock, readEnable;
  logic       wes, fullFlag, emptyFlag, orFlag, readValid;
  logic [7:0] sampleData = 8'h00, readData, expByte;
  logic [3:0] hist = 4'h0;
  logic [7:0] model[$];
  int         errorCnt = 0, checks = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  capture_buffer_control u_capture_buffer_control (.mclk(mclk), .rst_n(rst_n), .readClock(readClock),
    .readEnable(readEnable), .writeEnable(writeEnable), .resetPin(resetPin), .autoStopWrite(autoStopWrite),
    .sampleData(sampleData), .overRange(overRange), .writeEnableSynced(wes), .bufferFullFlag(fullFlag),
    .bufferEmptyFlag(emptyFlag), .outOfRangeFlag(orFlag), .readData(readData), .readValid(readValid));
  capture_reader u_capture_reader (.wantRead(wantRead), .writeEnable(writeEnable), .readClock(readClock),
    .readEnable(readEnable));
  always @(posedge mclk) begin
    #1 sampleData = 8'($urandom);
    overRange = ($urandom % 4) == 0;
  end
  // expected store, lagging the pin by the two-stage synchroniser
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      tally_and_finish();
    end
    if (hist[1] && !(autoStopWrite && expFull(model.size()))) begin
      if (expFull(model.size())) void'(model.pop_front());
      model.push_back(sampleData);
      expOr |= overRange;
    end
    hist <= {hist[2:0], writeEnable};
  end
  // synced copy trails the pin by the two synchroniser stages plus its own flop
  always @(negedge mclk) if (rst_n) `CHK(wes, hist[2])
  function automatic logic expFull(input int fill);
    return fill == int'(capture_pkg::DEPTH);
  endfunction : expFull
  function automatic logic expEmpty(input int fill);
    return fill == 0;
  endfunction : expEmpty
  task automatic wr(input int n, input logic auto_stop_write);
    @(posedge mclk);
    #1 autoStopWrite = auto_stop_write;
    writeEnable = 1'b1;
    repeat (n) @(posedge mclk);
    #1 writeEnable = 1'b0;
    repeat (6) @(negedge mclk);
  endtask : wr
  task automatic rd(input int n);
    int k;
    @(posedge mclk);
    #1 wantRead = 1'b1;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge mclk);
        k++;
      end while (readValid !== 1'b1 && k < 60);
      `CHK(readValid, 1'b1)
      expByte = (model.size() > 0) ? model.pop_front() : 8'h00;
      `CHK(readData, expByte)
    end
    @(posedge mclk);
    #1 wantRead = 1'b0;
    if (model.size() == 0) expOr = 1'b0;
    repeat (20) @(negedge mclk);
  endtask : rd
  task automatic clr();
    @(posedge mclk);
    #1 resetPin = 1'b1;
    repeat (4) @(posedge mclk);
    #1 resetPin = 1'b0;
    model.delete();
    expOr = 1'b0;
    repeat (4) @(negedge mclk);
    `CHK(emptyFlag, 1'b1)
    `CHK(fullFlag, 1'b0)
    `CHK(orFlag, 1'b0)
  endtask : clr
  task automatic tally_and_finish();
    if (errorCnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'h28a0abdf));
    repeat (8) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    `CHK(emptyFlag, 1'b1)
    `CHK(fullFlag, 1'b0)
    wr(20, 1'b0);
    `CHK(emptyFlag, expEmpty(model.size()))
    `CHK(orFlag, expOr)
    rd(20);
    `CHK(emptyFlag, expEmpty(model.size()))
    `CHK(orFlag, 1'b0)
    // overfill with stop set: oldest bytes must survive
    wr(4100, 1'b1);
    `CHK(fullFlag, expFull(model.size()))
    rd(2);
    `CHK(fullFlag, expFull(model.size()))
    `CHK(orFlag, expOr)
    clr();
    wr(4101, 1'b0);
    `CHK(fullFlag, expFull(model.size()))
    rd(3);
    `CHK(orFlag, expOr)
    clr();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
